// ### cib_regs.vh
/*
 constants for the compare-increment-branch execution unit.
 assumes it is included by bare name from the design files.
*/
`ifndef CIB_REGS_VH
`define CIB_REGS_VH
// opcodes
`define CIB_OPC_EQ        8'hC2
`define CIB_OPC_NE        8'hD2
// instruction length in bytes
`define CIB_LEN           16'h0003
// cycle counts
`define CIB_CYC_TAKEN     5'h12
`define CIB_CYC_NOTTAKEN  5'h10
`define CIB_CYC_ONE       5'h01
// pointer step
`define CIB_PTR_STEP      8'h01
`define CIB_ZERO8         8'h00
`define CIB_ZERO5         5'h00
`define CIB_ZERO16        16'h0000
`define CIB_ZERO4         4'h0
// compare happens once this count is reached
`define CIB_CYC_CMP       5'h04
// operand byte fields: destination index high, pointer index low
`define CIB_DST_FIELD     7:4
`define CIB_PTR_FIELD     3:0
`endif

// ### cib_file.v
/*
 small register file: 256 bytes, one write port, two read ports, read data
 registered. assumes a single synchronous clock.
*/
`timescale 1ns/1ps
module cib_file
(
  // clock
  input  wire       clk,
  // write port
  input  wire       we,
  input  wire [7:0] waddr,
  input  wire [7:0] wdata,
  // read ports
  input  wire [7:0] raddr_a,
  input  wire [7:0] raddr_b,
  output reg  [7:0] rdata_a,
  output reg  [7:0] rdata_b
);

  reg [7:0] mem [0:255];

  // ******************
  // storage and access
  // ******************
  // write and registered reads
  always @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end

endmodule

// ### cib_exec.v
/*
 execution unit for the compare-increment-branch pair of instructions.
 assumes decode presents three instruction bytes with a one-cycle start pulse,
 and owns the register file used for operands and the pointer.
*/
// How it works
// RULE1: opcode C2 three bytes equal variant
// RULE2: 18 cycles taken, 16 not taken
// RULE3: subtract source from destination, no writeback
// RULE4: equal variant branches when difference zero
// RULE5: unequal variant branches when values differ
// RULE6: pointer incremented by one always
// RULE7: status flags left untouched
// RULE8: displacement is signed eight bits
// RULE9: unequal variant has distinct opcode
// RULE10: displacement added to next instruction address
`timescale 1ns/1ps
`include "cib_regs.vh"
module cib_exec
(
  // clock and reset
  input  wire        clk,
  input  wire        srst,
  // instruction from decode
  input  wire        start,
  input  wire [7:0]  opcode,
  input  wire [7:0]  operand_regs,
  input  wire [7:0]  relative_displacement,
  input  wire [15:0] pc_in,
  input  wire [7:0]  flags_in,
  // results
  output reg         busy,
  output reg         done,
  output reg         taken,
  output reg  [15:0] pc_out,
  output reg  [7:0]  flags_out,
  output reg         illegal
);

  // ************
  // declarations
  // ************
  // one-hot sequencer states
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_READ = 5'h02;
  localparam [4:0] S_DATA = 5'h04;
  localparam [4:0] S_CMP  = 5'h08;
  localparam [4:0] S_WAIT = 5'h10;

  reg  [4:0]  state;
  reg  [4:0]  cnt;
  reg  [3:0]  dst_idx;
  reg  [3:0]  ptr_idx;
  reg  [7:0]  disp;
  reg  [15:0] seq_pc;
  reg         is_ne;
  reg  [7:0]  ptr_val;
  reg         we;
  reg  [7:0]  waddr;
  reg  [7:0]  wdata;
  reg  [7:0]  raddr_a;
  reg  [7:0]  raddr_b;
  wire [7:0]  rdata_a;
  wire [7:0]  rdata_b;
  wire [7:0]  diff;
  wire        eq;
  wire        go;
  wire        op_eq;
  wire        op_ne;
  wire        cmp_now;
  wire [4:0]  end_cnt;

  // *************
  // operand store
  // *************
  // pointer, destination and source bytes live here
  cib_file u_file
  (
    .clk     (clk),
    .we      (we),
    .waddr   (waddr),
    .wdata   (wdata),
    .raddr_a (raddr_a),
    .raddr_b (raddr_b),
    .rdata_a (rdata_a),
    .rdata_b (rdata_b)
  );

  // ******************
  // decode and compare
  // ******************
  // the two accepted opcodes; anything else is refused with a pulse
  assign op_eq = (opcode == `CIB_OPC_EQ); // RULE1
  assign op_ne = (opcode == `CIB_OPC_NE); // RULE9

  // compare by subtraction, result only feeds the branch test
  assign diff = rdata_a - rdata_b; // RULE3
  assign eq   = (diff == `CIB_ZERO8);
  assign go   = is_ne ? ~eq : eq; // RULE4 RULE5

  // the first cycle in which both operand reads are valid
  assign cmp_now = (state == S_CMP) && (cnt == `CIB_CYC_CMP);

  // last busy count depends on whether the branch was taken
  assign end_cnt = taken ? `CIB_CYC_TAKEN : `CIB_CYC_NOTTAKEN; // RULE2

  // *********
  // sequencer
  // *********
  // state, cycle count, operand latches and all outputs
  always @(posedge clk)
  begin
    if (srst)
    begin
      state     <= S_IDLE;
      cnt       <= `CIB_ZERO5;
      busy      <= 1'b0;
      done      <= 1'b0;
      taken     <= 1'b0;
      illegal   <= 1'b0;
      pc_out    <= `CIB_ZERO16;
      flags_out <= `CIB_ZERO8;
      dst_idx   <= `CIB_ZERO4;
      ptr_idx   <= `CIB_ZERO4;
      disp      <= `CIB_ZERO8;
      seq_pc    <= `CIB_ZERO16;
      is_ne     <= 1'b0;
      ptr_val   <= `CIB_ZERO8;
      raddr_a   <= `CIB_ZERO8;
      raddr_b   <= `CIB_ZERO8;
    end
    else
    begin
      // done and illegal are one-cycle pulses
      done    <= 1'b0;
      illegal <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (start)
          begin
            // latch operands, fall-through address and flags
            if (op_eq || op_ne) // RULE1 RULE9
            begin
              is_ne     <= op_ne; // RULE9
              dst_idx   <= operand_regs[`CIB_DST_FIELD];
              ptr_idx   <= operand_regs[`CIB_PTR_FIELD];
              disp      <= relative_displacement;
              seq_pc    <= pc_in + `CIB_LEN; // RULE10
              flags_out <= flags_in; // RULE7
              raddr_b   <= {`CIB_ZERO4, operand_regs[`CIB_PTR_FIELD]};
              busy      <= 1'b1;
              cnt       <= `CIB_CYC_ONE;
              state     <= S_READ;
            end
            else
              illegal <= 1'b1;
          end
        end
        S_READ:
        begin
          // pointer value arrives next cycle
          cnt   <= cnt + `CIB_CYC_ONE;
          state <= S_DATA;
        end
        S_DATA:
        begin
          // pointer has arrived: fetch destination and the pointed byte
          ptr_val <= rdata_b;
          raddr_a <= {`CIB_ZERO4, dst_idx};
          raddr_b <= rdata_b;
          cnt     <= cnt + `CIB_CYC_ONE;
          state   <= S_CMP;
        end
        S_CMP:
        begin
          // wait one cycle for both operand reads
          if (cmp_now)
          begin
            taken <= go;
            if (go)
              pc_out <= seq_pc + {{8{disp[7]}}, disp}; // RULE8
            else
              pc_out <= seq_pc;
            state <= S_WAIT;
          end
          cnt <= cnt + `CIB_CYC_ONE;
        end
        S_WAIT:
        begin
          // pad to the documented execution time
          if (cnt == end_cnt) // RULE2
          begin
            busy  <= 1'b0;
            done  <= 1'b1;
            state <= S_IDLE;
          end
          else
            cnt <= cnt + `CIB_CYC_ONE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // *****************
  // pointer writeback
  // *****************
  // one write, requested on the compare cycle, enabled the cycle after and done on the edge that ends it; operands themselves are never written
  always @(posedge clk)
  begin
    if (srst)
    begin
      we    <= 1'b0;
      waddr <= `CIB_ZERO8;
      wdata <= `CIB_ZERO8;
    end
    else
    begin
      we <= 1'b0;
      if (cmp_now)
      begin
        we    <= 1'b1; // RULE6
        waddr <= {`CIB_ZERO4, ptr_idx};
        wdata <= ptr_val + `CIB_PTR_STEP; // RULE6
      end
    end
  end

endmodule

// ### cib_exec_props.sv
/* checks on the ports of cib_exec
   assumes one clock, srst sync high */
`timescale 1ns/1ps
module cib_chk
(
  // clock and reset
  input wire        clk,
  input wire        srst,
  // request
  input wire        start,
  input wire [7:0]  opcode,
  input wire [7:0]  relative_displacement,
  input wire [15:0] pc_in,
  input wire [7:0]  flags_in,
  // result
  input wire        busy,
  input wire        done,
  input wire        taken,
  input wire [15:0] pc_out,
  input wire [7:0]  flags_out,
  input wire        illegal
);
  // ******
  // checks
  // ******
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // request made while not busy, any opcode
  wire       go = start && !busy;
  wire [7:0] dsp = relative_displacement;
  AST_ACC: assert property (go && opcode == 8'hC2 |=> busy && !illegal)
    else $error("not accepted");
  AST_BAD: assert property (go && opcode != 8'hC2 && opcode != 8'hD2 |=> illegal)
    else $error("no illegal");
  // busy spans 18 or 16 edges; done shows on the edge after the last one
  AST_LAT_T: assert property (done && taken |-> $past(go, 19))
    else $error("taken time");
  AST_LAT_N: assert property (done && !taken |-> $past(go, 17))
    else $error("fall time");
  AST_PC_T: assert property (done && taken |-> pc_out == $past(pc_in, 19) + 16'h0003
    + {{8{$past(dsp[7], 19)}}, $past(dsp, 19)}) else $error("target");
  AST_PC_N: assert property (done && !taken |-> pc_out == $past(pc_in, 17) + 16'h0003)
    else $error("next pc");
  AST_FLG: assert property (done |-> flags_out == (taken ? $past(flags_in, 19)
    : $past(flags_in, 17))) else $error("flags");
  AST_PUL: assert property (done |-> !busy ##1 !done)
    else $error("done pulse");
  C_T: cover property (done && taken);
  C_N: cover property (done && !taken);
  C_I: cover property (illegal);
endmodule
bind cib_exec cib_chk u_chk
(
  .clk                   (clk),
  .srst                  (srst),
  .start                 (start),
  .opcode                (opcode),
  .relative_displacement (relative_displacement),
  .pc_in                 (pc_in),
  .flags_in              (flags_in),
  .busy                  (busy),
  .done                  (done),
  .taken                 (taken),
  .pc_out                (pc_out),
  .flags_out             (flags_out),
  .illegal               (illegal)
);

// ### tb.sv
/* testbench for cib_exec
   drives the ports directly */
`timescale 1ns/1ps
module tb;
  // *****
  // bench
  // *****
  reg         clk = 0;
  reg         srst = 1;
  reg         start = 0;
  reg  [7:0]  opcode = 8'h00;
  reg  [7:0]  operand_regs = 8'h12;
  reg  [7:0]  relative_displacement = 8'h00;
  reg  [15:0] pc_in = 16'h0000;
  reg  [7:0]  flags_in = 8'h00;
  wire        busy, done, taken, illegal;
  wire [15:0] pc_out;
  wire [7:0]  flags_out;
  integer     failures = 0;
  integer     n_tests = 0;
  integer     n;
  reg  [7:0]  dst_v = 8'h00;
  reg  [7:0]  ptr_v = 8'h00;
  reg  [7:0]  src_v = 8'h00;
  cib_exec u_dut
  (
    .clk                   (clk),
    .srst                  (srst),
    .start                 (start),
    .opcode                (opcode),
    .operand_regs          (operand_regs),
    .relative_displacement (relative_displacement),
    .pc_in                 (pc_in),
    .flags_in              (flags_in),
    .busy                  (busy),
    .done                  (done),
    .taken                 (taken),
    .pc_out                (pc_out),
    .flags_out             (flags_out),
    .illegal               (illegal)
  );
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  // compare and count
  task check(input [15:0] got, input [15:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // preload the operand file: destination, pointer and the byte it points at
  task load(input [7:0] regs, input [7:0] dv, input [7:0] pv, input [7:0] sv);
    operand_regs = regs;
    dst_v = dv;
    ptr_v = pv;
    src_v = sv;
    u_dut.u_file.mem[{4'h0, regs[7:4]}] = dv;
    u_dut.u_file.mem[{4'h0, regs[3:0]}] = pv;
    u_dut.u_file.mem[pv] = sv;
  endtask
  // one instruction, with a stray start while busy
  task run(input [7:0] op, input [7:0] d, input [15:0] p, input [7:0] f, input exp_t);
    opcode = op;
    relative_displacement = d;
    pc_in = p;
    flags_in = f;
    start = 1;
    @(posedge clk);
    #1;
    n = 1;
    opcode = 8'hFF;
    flags_in = ~f;
    while (!done && n < 40)
    begin
      start = (n == 3);
      @(posedge clk);
      #1;
      n = n + 1;
      if (n == 4)
        check(illegal, 0);
    end
    check(n >= 40, 0);
    if (n >= 40)
      give_verdict;
    check(taken, exp_t);
    // busy covers every edge after the start but the one that shows done
    if (exp_t)
    begin
      check(n[15:0] - 16'h0001, 18);
      check(pc_out, p + 16'h0003 + {{8{d[7]}}, d});
    end
    else
    begin
      check(n[15:0] - 16'h0001, 16);
      check(pc_out, p + 16'h0003);
    end
    check(flags_out, f);
    check(u_dut.u_file.mem[{4'h0, operand_regs[3:0]}], ptr_v + 8'h01);
    check(u_dut.u_file.mem[{4'h0, operand_regs[7:4]}], dst_v);
    check(u_dut.u_file.mem[ptr_v], src_v);
  endtask
  task t_eq;
    load(8'h12, 8'h55, 8'h30, 8'h55);
    run(8'hC2, 8'h7F, 16'h1000, 8'hA5, 1'b1);
    $display("equal variant done");
  endtask
  task t_eq_miss;
    load(8'h12, 8'h02, 8'h30, 8'h03);
    run(8'hC2, 8'h80, 16'h2000, 8'h0F, 1'b0);
    $display("equal variant fall-through done");
  endtask
  task t_ne;
    load(8'h34, 8'h02, 8'hF0, 8'h04);
    run(8'hD2, 8'h80, 16'h0010, 8'h3C, 1'b1);
    $display("unequal variant done");
  endtask
  task t_ne_miss;
    load(8'h34, 8'h7E, 8'hF0, 8'h7E);
    run(8'hD2, 8'h10, 16'hFFF0, 8'h00, 1'b0);
    $display("unequal variant fall-through done");
  endtask
  task t_bad;
    opcode = 8'h5A;
    start = 1;
    @(posedge clk);
    #1;
    start = 0;
    check(illegal, 1);
    check(busy, 0);
    $display("bad opcode done");
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    srst = 0;
    check({busy, done, taken, illegal}, 0);
    t_eq;
    t_eq_miss;
    t_ne;
    t_ne_miss;
    t_bad;
    give_verdict;
  end
endmodule
